//--- design/rxf_pkg.sv
/*
 Shared constants and carrier types of the receive address and wake-up
 frame filter: register offsets, field positions, reset values, CRC
 parameters and the byte and verdict structs.
 Assumes a single clock domain and a byte-wide receive stream.
*/
package rxf_pkg;

  localparam int ADDR_W = 8;
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_STA_LO = 8'h04;
  localparam logic [7:0] OFF_STA_HI = 8'h08;
  localparam logic [7:0] OFF_HASH_LO = 8'h0C;
  localparam logic [7:0] OFF_HASH_HI = 8'h10;
  localparam logic [7:0] OFF_WAKE_CS = 8'h14;
  localparam logic [7:0] OFF_WAKE_PORT = 8'h18;
  localparam logic [7:0] OFF_STATUS = 8'h1C;

  localparam int CTRL_W = 6;
  localparam int CTRL_MC_PASS = 0;
  localparam int CTRL_PROMISC = 1;
  localparam int CTRL_INVERSE = 2;
  localparam int CTRL_HASH_ONLY = 3;
  localparam int CTRL_HASH_PERF = 4;
  localparam int CTRL_BROADCAST_DISABLE_DIS = 5;
  localparam logic [5:0] CTRL_RST = 6'h00;

  localparam int WCS_EN = 0;
  localparam int WCS_RCVD = 1;
  localparam int WCS_PME_SEL = 2;
  localparam int WCS_D1 = 3;

  localparam int ST_WAKE_MODE = 0;
  localparam int ST_LAST_ACC = 1;
  localparam int ST_PTR_LSB = 4;

  localparam int N_FILT = 4;
  localparam int MASK_LEN = 31;
  localparam int CMD_EN = 0;
  localparam int CMD_MCAST = 3;
  localparam logic [2:0] WP_CMD = 3'h4;
  localparam logic [2:0] WP_OFF = 3'h5;
  localparam logic [2:0] WP_CRC01 = 3'h6;
  localparam logic [2:0] WP_CRC23 = 3'h7;

  localparam int DA_BYTES = 6;
  localparam int HASH_IDX_LSB = 26;
  localparam logic [31:0] CRC32_POLY = 32'h04C11DB7;
  localparam logic [31:0] CRC32_INIT = 32'hFFFFFFFF;
  localparam logic [15:0] CRC16_POLY = 16'h8005;
  localparam logic [15:0] CRC16_INIT = 16'hFFFF;

  typedef struct packed {
    logic valid;
    logic sof;
    logic eof;
    logic [7:0] data;
  } rxf_byte_t;

  typedef struct packed {
    logic valid;
    logic accept;
    logic mcast;
    logic broadcast_disable;
  } rxf_verdict_t;

endpackage

//--- design/rxf_crc.sv
/*
 Byte-serial CRC register, data taken least significant bit first.
 Assumes init and en come from logic on the same clock.
*/
`timescale 1ns/1ps
module rxf_crc #(
  parameter int W = 32,
  parameter logic [W-1:0] POLY = '1,
  parameter logic [W-1:0] INIT = '1
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic ce,
  input wire logic init,
  input wire logic en,
  input wire logic [7:0] data,
  output logic [W-1:0] crc
);

  if (W < 8 || W > 32) begin : g_chk
    $error("CRC width must lie between 8 and 32.");
  end

  function automatic logic [W-1:0] step(input logic [W-1:0] c,
                                        input logic [7:0] d);
    logic [W-1:0] r;
    logic fb;
    r = c;
    for (int i = 0; i < 8; i++) begin
      fb = r[W-1] ^ d[i];
      r = {r[W-2:0], 1'b0} ^ (fb ? POLY : '0);
    end
    return r;
  endfunction

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      crc <= '1;
    end else if (ce) begin
      if (en) begin
        crc <= step(init ? INIT : crc, data);
      end else if (init) begin
        crc <= INIT;
      end
    end
  end

endmodule

//--- design/rxf_wake_match.sv
/*
 One wake-up pattern filter: selects the masked bytes of the window that
 starts at the programmed offset and runs them through a CRC-16.
 Assumes the byte index is zero on the first destination address byte.
*/
`timescale 1ns/1ps
module rxf_wake_match
  import rxf_pkg::*;
#(
  parameter int BIDX_W = 11
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic ce,
  input wire rxf_pkg::rxf_byte_t rx,
  input wire logic [BIDX_W-1:0] bidx,
  input wire logic [30:0] mask,
  input wire logic [7:0] offset,
  input wire logic [15:0] expect_crc,
  output logic hit
);

  logic [BIDX_W-1:0] rel;
  logic in_win;
  logic [15:0] crc;

  // The window is byte offset+j for mask bit j, j below 31.
  always_comb begin
    rel = bidx - BIDX_W'(offset);
    in_win = (bidx >= BIDX_W'(offset)) && (rel < BIDX_W'(MASK_LEN)) &&
             mask[rel[4:0]];
  end

  rxf_crc #(.W(16), .POLY(CRC16_POLY), .INIT(CRC16_INIT)) u_crc (
    .hclk(hclk),
    .hresetn(hresetn),
    .ce(ce),
    .init(rx.valid && rx.sof),
    .en(rx.valid && in_win),
    .data(rx.data),
    .crc(crc)
  );

  assign hit = (crc == expect_crc);

endmodule

//--- design/rxf_rx_filter.sv
/*
 Receive destination address filter and wake-up frame detector with an
 AHB-Lite register slave.
 Assumes the receive stream and the bus run on hclk; a single master
 issuing word transfers only.
*/
// Local design decisions: the address map and register access over AHB-Lite.
// Function
// - Perfect mode accepts only a destination equal to the station address.
// - Hash uses CRC of destination; top six bits index a 64-bit table.
// - Index MSB picks high or low hash word, five bits pick the bit.
// - Hash-only mode hash-checks every frame, multicast or physical.
// - Hash-perfect mode: physical perfect-matched, multicast hash-checked.
// - Inverse mode accepts non-matching and rejects matching destinations.
// - Pass-all-multicast accepts every multicast frame in any mode, except broadcast with broadcast disable set.
// - Promiscuous accepts every frame, broadcast included.
// - Wake enable suppresses normal reception; only patterns are checked.
// - Wake frame sets received status and notifies by interrupt or event.
// - Clearing wake enable returns to normal reception; the code stays in wake mode while the low-power state bit is set.
// - Wake frame: enabled filter with passing address type and CRC.
// - Mask bit j feeds byte offset+j into CRC; bit 31 stays zero.
// - Low-power state forces wake detection on regardless of enable.
// - Matching broadcast wakes even with broadcast disable set.
// - Command bit 3 picks multicast or unicast; bits 2:1 reserved.
// - Command bit 0 enables the filter; disabled filters never match.
// - Pattern offset is an 8-bit byte index from destination start.
// - Each filter compares its expected CRC-16 with the computed one.
`timescale 1ns/1ps
module rxf_rx_filter #(
  parameter int BIDX_W = 11
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic ce,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire rxf_pkg::rxf_byte_t rx,
  output rxf_pkg::rxf_verdict_t verdict,
  output logic host_irq,
  output logic power_event_output
);
  import rxf_pkg::*;

  if (BIDX_W < 9 || BIDX_W > 16) begin : g_chk
    $error("Byte index must reach offset 255 plus 30.");
  end

  logic [CTRL_W-1:0] ctrl_q;
  logic [31:0] sta_lo_q, hash_lo_q, hash_hi_q, hcrc;
  logic [15:0] sta_hi_q;
  logic wake_frame_enable_q, wake_frame_received_q, pme_sel_q, d1_q;
  logic [30:0] mask_q [N_FILT];
  logic [3:0] cmd_q [N_FILT];
  logic [7:0] offs_q [N_FILT];
  logic [15:0] fcrc_q [N_FILT];
  logic [2:0] wp_q;
  logic [7:0] dp_addr_q;
  logic [BIDX_W-1:0] bcnt_q, bidx;
  logic [47:0] da_q;
  logic dp_wr_q, rd_pend_q, dec_q, eof_q, da_seen_q, addr_ok_q, mcast_q;
  logic last_acc_q, ap, port_wr, port_rd;
  logic wake_mode, perfect, hash_hit, mcast, broadcast_disable, accept, wake_hit;
  logic [N_FILT-1:0] f_hit, f_ok;

  function automatic logic [31:0] port_word(input logic [2:0] i);
    logic [31:0] w;
    w = '0;
    if (i < WP_CMD) begin
      w = {1'b0, mask_q[i[1:0]]};
    end else begin
      for (int k = 0; k < N_FILT; k++) begin
        unique case (i)
          WP_CMD: w[8*k +: 4] = cmd_q[k];
          WP_OFF: w[8*k +: 8] = offs_q[k];
          WP_CRC01: if (k < 2) w[16*k +: 16] = fcrc_q[k];
          default: if (k >= 2) w[16*(k-2) +: 16] = fcrc_q[k];
        endcase
      end
    end
    return w;
  endfunction

  function automatic logic [31:0] rd_word(input logic [7:0] a);
    logic [31:0] w;
    w = '0;
    unique case (a)
      OFF_CTRL: w = {{(32-CTRL_W){1'b0}}, ctrl_q};
      OFF_STA_LO: w = sta_lo_q;
      OFF_STA_HI: w = {16'h0000, sta_hi_q};
      OFF_HASH_LO: w = hash_lo_q;
      OFF_HASH_HI: w = hash_hi_q;
      OFF_WAKE_CS: w[WCS_D1:WCS_EN] = {d1_q, pme_sel_q,
        wake_frame_received_q, wake_frame_enable_q};
      OFF_WAKE_PORT: w = port_word(wp_q);
      OFF_STATUS: begin
        w[ST_WAKE_MODE] = wake_mode;
        w[ST_LAST_ACC] = last_acc_q;
        w[ST_PTR_LSB +: 3] = wp_q;
      end
      default: w = '0;
    endcase
    return w;
  endfunction

  // Reads take one wait state so that a write in the preceding data phase
  // is already stored when the read word is formed.
  assign ap = hsel && hready && htrans[1];
  assign port_wr = dp_wr_q && (dp_addr_q == OFF_WAKE_PORT);
  assign port_rd = rd_pend_q && (dp_addr_q == OFF_WAKE_PORT);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dp_wr_q <= 1'b0;
      rd_pend_q <= 1'b0;
      dp_addr_q <= 8'h00;
      hreadyout <= 1'b1;
      hrdata <= 32'h00000000;
      hresp <= 1'b0;
    end else if (ce) begin
      dp_wr_q <= ap && hwrite;
      rd_pend_q <= ap && !hwrite;
      if (ap) begin
        dp_addr_q <= {haddr[7:2], 2'b00};
      end
      if (ap && !hwrite) begin
        hreadyout <= 1'b0;
      end else if (rd_pend_q) begin
        hreadyout <= 1'b1;
        hrdata <= rd_word(dp_addr_q);
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl_q <= CTRL_RST;
      sta_lo_q <= 32'h00000000;
      sta_hi_q <= 16'h0000;
      hash_lo_q <= 32'h00000000;
      hash_hi_q <= 32'h00000000;
    end else if (ce && dp_wr_q) begin
      unique case (dp_addr_q)
        OFF_CTRL: ctrl_q <= hwdata[CTRL_W-1:0];
        OFF_STA_LO: sta_lo_q <= hwdata;
        OFF_STA_HI: sta_hi_q <= hwdata[15:0];
        OFF_HASH_LO: hash_lo_q <= hwdata;
        OFF_HASH_HI: hash_hi_q <= hwdata;
        default: ;
      endcase
    end
  end

  // A detection in the same cycle as a clearing write keeps the flag set.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wake_frame_enable_q <= 1'b0;
      wake_frame_received_q <= 1'b0;
      pme_sel_q <= 1'b0;
      d1_q <= 1'b0;
    end else if (ce) begin
      if (dp_wr_q && dp_addr_q == OFF_WAKE_CS) begin
        wake_frame_enable_q <= hwdata[WCS_EN];
        pme_sel_q <= hwdata[WCS_PME_SEL];
        d1_q <= hwdata[WCS_D1];
      end
      if (wake_hit) begin
        wake_frame_received_q <= 1'b1;
      end else if (dp_wr_q && dp_addr_q == OFF_WAKE_CS && hwdata[WCS_RCVD]) begin
        wake_frame_received_q <= 1'b0;
      end
    end
  end

  // The port pointer wraps after the eighth word; reads step it as well.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wp_q <= 3'h0;
      for (int k = 0; k < N_FILT; k++) begin
        mask_q[k] <= '0;
        cmd_q[k] <= 4'h0;
        offs_q[k] <= 8'h00;
        fcrc_q[k] <= 16'h0000;
      end
    end else if (ce && (port_wr || port_rd)) begin
      wp_q <= wp_q + 3'h1;
      if (port_wr) begin
        if (wp_q < WP_CMD) begin
          mask_q[wp_q[1:0]] <= hwdata[30:0];
        end else begin
          for (int k = 0; k < N_FILT; k++) begin
            unique case (wp_q)
              WP_CMD: begin
                cmd_q[k] <= {hwdata[8*k+CMD_MCAST], 2'b00,
                             hwdata[8*k+CMD_EN]};
              end
              WP_OFF: offs_q[k] <= hwdata[8*k +: 8];
              WP_CRC01: if (k < 2) fcrc_q[k] <= hwdata[16*k +: 16];
              default: if (k >= 2) fcrc_q[k] <= hwdata[16*(k-2) +: 16];
            endcase
          end
        end
      end
    end
  end

  assign bidx = rx.sof ? '0 : bcnt_q;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      bcnt_q <= '0;
      da_q <= 48'h000000000000;
      dec_q <= 1'b0;
      eof_q <= 1'b0;
    end else if (ce) begin
      dec_q <= rx.valid && (bidx == BIDX_W'(DA_BYTES - 1));
      eof_q <= rx.valid && rx.eof;
      if (rx.valid) begin
        if (bidx != '1) begin
          bcnt_q <= bidx + BIDX_W'(1);
        end
        if (bidx < BIDX_W'(DA_BYTES)) begin
          da_q[8*bidx[2:0] +: 8] <= rx.data;
        end
      end
    end
  end

  rxf_crc #(.W(32), .POLY(CRC32_POLY), .INIT(CRC32_INIT)) u_hash_crc (
    .hclk(hclk),
    .hresetn(hresetn),
    .ce(ce),
    .init(rx.valid && rx.sof),
    .en(rx.valid && (bidx < BIDX_W'(DA_BYTES))),
    .data(rx.data),
    .crc(hcrc)
  );

  for (genvar g = 0; g < N_FILT; g++) begin : g_filt
    rxf_wake_match #(.BIDX_W(BIDX_W)) u_match (
      .hclk(hclk),
      .hresetn(hresetn),
      .ce(ce),
      .rx(rx),
      .bidx(bidx),
      .mask(mask_q[g]),
      .offset(offs_q[g]),
      .expect_crc(fcrc_q[g]),
      .hit(f_hit[g])
    );
    assign f_ok[g] = cmd_q[g][CMD_EN] && f_hit[g] &&
                     (cmd_q[g][CMD_MCAST] == mcast_q);
  end

  assign wake_mode = wake_frame_enable_q || d1_q;

  // The hash is imperfect: different addresses may share one table bit.
  always_comb begin
    perfect = (da_q == {sta_hi_q, sta_lo_q});
    hash_hit = hcrc[31] ? hash_hi_q[hcrc[30:HASH_IDX_LSB]] :
               hash_lo_q[hcrc[30:HASH_IDX_LSB]];
    mcast = da_q[0];
    broadcast_disable = &da_q;
    if (ctrl_q[CTRL_PROMISC]) begin
      accept = 1'b1;
    end else if (mcast && ctrl_q[CTRL_MC_PASS]) begin
      accept = !(broadcast_disable && ctrl_q[CTRL_BROADCAST_DISABLE_DIS]);
    end else if (broadcast_disable && ctrl_q[CTRL_BROADCAST_DISABLE_DIS]) begin
      accept = 1'b0;
    end else if (ctrl_q[CTRL_INVERSE]) begin
      accept = !perfect;
    end else if (ctrl_q[CTRL_HASH_ONLY]) begin
      accept = hash_hit;
    end else if (ctrl_q[CTRL_HASH_PERF]) begin
      accept = mcast ? hash_hit : perfect;
    end else begin
      accept = perfect;
    end
    wake_hit = eof_q && wake_mode && da_seen_q && addr_ok_q && (|f_ok);
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      verdict <= '0;
      da_seen_q <= 1'b0;
      addr_ok_q <= 1'b0;
      mcast_q <= 1'b0;
      last_acc_q <= 1'b0;
    end else if (ce) begin
      verdict.valid <= dec_q;
      if (dec_q) begin
        verdict.accept <= accept && !wake_mode;
        verdict.mcast <= mcast;
        verdict.broadcast_disable <= broadcast_disable;
        last_acc_q <= accept && !wake_mode;
        addr_ok_q <= perfect || mcast;
        mcast_q <= mcast;
        da_seen_q <= 1'b1;
      end else if (rx.valid && rx.sof) begin
        da_seen_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      host_irq <= 1'b0;
      power_event_output <= 1'b0;
    end else if (ce) begin
      host_irq <= wake_frame_received_q && !pme_sel_q;
      power_event_output <= wake_frame_received_q && pme_sel_q;
    end
  end

  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn || !ce);

  sequence port_wr_s;
    port_wr ##1 1'b1;
  endsequence

  promisc_accept_a: assert property (
    dec_q && ctrl_q[CTRL_PROMISC] && !wake_mode |=> verdict.accept)
    else $error("Promiscuous frame not accepted.");
  mcast_pass_a: assert property (
    dec_q && ctrl_q[CTRL_MC_PASS] && mcast && !broadcast_disable && !wake_mode
    |=> verdict.valid && verdict.accept)
    else $error("Multicast frame not passed.");
  inverse_reject_a: assert property (
    dec_q && ctrl_q == 6'h04 && perfect |=> verdict.valid && !verdict.accept)
    else $error("Inverse mode accepted own address.");
  perfect_match_a: assert property (
    dec_q && ctrl_q == 6'h00 && !wake_mode
    |=> verdict.accept == $past(da_q == {sta_hi_q, sta_lo_q}))
    else $error("Perfect filter decision wrong.");
  wake_suppress_a: assert property (
    dec_q && wake_mode |=> verdict.valid && !verdict.accept)
    else $error("Normal reception during wake mode.");
  wake_status_a: assert property (
    wake_hit |=> wake_frame_received_q ##1
    (host_irq != pme_sel_q) && (power_event_output == pme_sel_q))
    else $error("Wake detection not reported.");
  disabled_filter_a: assert property (
    wake_hit |-> |(f_hit & {cmd_q[3][0], cmd_q[2][0], cmd_q[1][0],
                            cmd_q[0][0]}))
    else $error("Wake match from a disabled filter.");
  d1_forced_a: assert property (
    d1_q |-> wake_mode)
    else $error("Low-power state did not force wake mode.");
  port_order_a: assert property (
    port_wr_s |-> wp_q == $past(wp_q) + 3'h1)
    else $error("Filter port pointer did not step.");
  frame_verdict_a: assert property (
    rx.valid && bidx == BIDX_W'(DA_BYTES - 1) |-> ##2 verdict.valid)
    else $error("No verdict after destination address.");

endmodule

//--- bench/rxf_rx_source.sv
/*
 Model of the MAC receive datapath that feeds bytes to the filter.
 Assumes the caller runs on hclk; idle cycles show inverted data.
*/
`timescale 1ns/1ps
module rxf_rx_source
  import rxf_pkg::*;
(
  input wire logic hclk,
  output rxf_pkg::rxf_byte_t rx
);
  import rxf_pkg::*;

  initial rx = '0;

  // Gaps between bytes stress the byte index counting of the filter.
  task automatic send(input logic [7:0] fr[$], input int gap);
    for (int i = 0; i < fr.size(); i++) begin
      @(posedge hclk);
      rx <= '{1'b1, i == 0, i == fr.size() - 1, fr[i]};
      repeat (gap) begin
        @(posedge hclk);
        rx <= '{1'b0, 1'b0, 1'b0, ~fr[i]};
      end
    end
    @(posedge hclk);
    rx <= '{1'b0, 1'b0, 1'b0, ~fr[fr.size() - 1]};
  endtask
endmodule

//--- bench/rxf_rx_filter_tb.sv
/*
 Self-checking bench of the receive address and wake-up frame filter.
 Assumes the AHB-Lite slave is the only one on the bus.
*/
`timescale 1ns/1ps
`define check_eq(nm, ex, gt) begin num_checks++; if ((gt) !== (ex)) begin \
  error_cnt++; $display("BAD %s exp %0h got %0h", nm, ex, gt); end end
module rxf_rx_filter_tb;
  import rxf_pkg::*;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata;
  logic hreadyout;
  logic hresp;
  rxf_byte_t rx;
  rxf_verdict_t verdict;
  rxf_verdict_t v_last;
  logic host_irq;
  logic power_event_output;
  int error_cnt = 0;
  int num_checks = 0;
  int v_cnt = 0;
  logic [31:0] seed = 32'h00010FDC;
  logic [47:0] sta;
  logic [31:0] hlo;
  logic [31:0] hhi;
  logic [7:0] fr[$];

  always #2.5 hclk = ~hclk;

  rxf_rx_filter rxf_rx_filter_i (.hclk(hclk), .hresetn(hresetn), .ce(1'b1),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .rx(rx), .verdict(verdict),
    .host_irq(host_irq), .power_event_output(power_event_output));
  rxf_rx_source rxf_rx_source_i (.hclk(hclk), .rx(rx));

  always @(posedge hclk) begin
    if (verdict.valid === 1'b1) begin
      v_cnt <= v_cnt + 1;
      v_last <= verdict;
    end
  end

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  function automatic logic [31:0] crc_b(logic [31:0] c, logic [31:0] p,
                                        int w, logic [7:0] d);
    logic fb;
    for (int i = 0; i < 8; i++) begin
      fb = c[w - 1] ^ d[i];
      c = c << 1;
      if (fb) c ^= p;
    end
    if (w == 16) c[31:16] = 16'h0000;
    return c;
  endfunction

  function automatic logic hash_hit(logic [47:0] da);
    logic [31:0] c;
    c = CRC32_INIT;
    for (int b = 0; b < 6; b++) c = crc_b(c, CRC32_POLY, 32, da[8*b+:8]);
    return c[31] ? hhi[c[30:26]] : hlo[c[30:26]];
  endfunction

  function automatic logic exp_acc(logic [47:0] da, logic [5:0] c);
    logic mc;
    logic bc;
    logic pm;
    mc = da[0];
    bc = &da;
    pm = (da == sta);
    if (c[CTRL_PROMISC]) return 1'b1;
    if (c[CTRL_MC_PASS] && mc) return !(bc && c[CTRL_BROADCAST_DISABLE_DIS]);
    if (bc && c[CTRL_BROADCAST_DISABLE_DIS]) return 1'b0;
    if (c[CTRL_INVERSE]) return !pm;
    if (c[CTRL_HASH_ONLY]) return hash_hit(da);
    if (c[CTRL_HASH_PERF]) return mc ? hash_hit(da) : pm;
    return pm;
  endfunction

  task automatic ahb(input logic w, input logic [7:0] a,
                     input logic [31:0] wd, output logic [31:0] rd);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= {24'h000000, a};
    hwrite <= w;
    htrans <= 2'h2;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    htrans <= 2'h0;
    hwdata <= wd;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    rd = hrdata;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] x;
    ahb(1'b1, a, d, x);
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] ex);
    logic [31:0] x;
    ahb(1'b0, a, 32'h0, x);
    `check_eq("hrdata", ex, x)
    `check_eq("hresp", 1'b0, hresp)
  endtask

  task automatic mk(input logic [47:0] da, input int len);
    logic [31:0] t;
    fr.delete();
    for (int b = 0; b < len; b++) begin
      t = rnd();
      fr.push_back(b < 6 ? da[8*b+:8] : t[7:0]);
    end
  endtask

  task automatic send_v();
    int n0;
    logic [31:0] t;
    n0 = v_cnt;
    t = rnd();
    rxf_rx_source_i.send(fr, int'(t[1:0]) % 3);
    for (int i = 0; i < 40 && v_cnt == n0; i++) @(posedge hclk);
    `check_eq("verdict count", n0 + 1, v_cnt)
  endtask

  task automatic wake_case(input int f, input logic mct, input logic en,
                           input logic [47:0] da, input logic [5:0] ctrl,
                           input logic [3:0] wcs, input logic bad,
                           input logic ex);
    logic [31:0] m;
    logic [31:0] w[8];
    logic [31:0] c;
    logic [7:0] off;
    m = rnd();
    off = 8'h0D + {5'h00, m[2:0]};
    m = rnd();
    mk(da, 64);
    c = {16'h0000, CRC16_INIT};
    for (int j = 0; j < 31; j++) begin
      if (m[j]) c = crc_b(c, {16'h0000, CRC16_POLY}, 16, fr[off + j]);
    end
    if (bad) c[0] = ~c[0];
    foreach (w[i]) w[i] = 32'h0;
    w[f] = m;
    w[4][8*f+:8] = {4'h0, mct, 2'b00, en};
    w[5][8*f+:8] = off;
    w[6 + f / 2][16*(f % 2)+:16] = c[15:0];
    wr(OFF_WAKE_CS, 32'h00000002);
    // The pattern set goes in before detection is switched on.
    for (int i = 0; i < 8; i++) wr(OFF_WAKE_PORT, w[i]);
    wr(OFF_CTRL, {26'h0, ctrl});
    wr(OFF_WAKE_CS, {28'h0, wcs});
    send_v();
    `check_eq("wake accept", 1'b0, v_last.accept)
    repeat (6) @(posedge hclk);
    rd_chk(OFF_WAKE_CS, {28'h0, wcs} | {30'h0, ex, 1'b0});
    `check_eq("irq", ex & ~wcs[2], host_irq)
    `check_eq("pme", ex & wcs[2], power_event_output)
  endtask

  task automatic report_and_stop();
    if (error_cnt == 0 && num_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  initial begin
    repeat (30000) @(posedge hclk);
    error_cnt++;
    report_and_stop();
  end

  initial begin
    logic [31:0] t;
    logic [31:0] w[8];
    logic [47:0] da;
    logic [5:0] ctrl;
    logic [5:0] tbl[8];
    tbl = '{6'h00, 6'h10, 6'h18, 6'h04, 6'h02, 6'h01, 6'h19, 6'h11};
    repeat (3) @(posedge hclk);
    hresetn <= 1'b1;
    rd_chk(OFF_CTRL, 32'h0);
    rd_chk(OFF_WAKE_CS, 32'h0);
    wr(8'h3C, 32'hFFFFFFFF);
    rd_chk(8'h3C, 32'h0);
    t = rnd();
    sta = {t[15:0], rnd()};
    sta[0] = 1'b0;
    hlo = rnd();
    hhi = rnd();
    wr(OFF_STA_LO, sta[31:0]);
    wr(OFF_STA_HI, {16'h0000, sta[47:32]});
    wr(OFF_HASH_LO, hlo);
    wr(OFF_HASH_HI, hhi);
    for (int i = 0; i < 8; i++) begin
      w[i] = rnd();
      wr(OFF_WAKE_PORT, w[i]);
    end
    for (int i = 0; i < 8; i++) begin
      t = i < 4 ? w[i] & 32'h7FFFFFFF : i == 4 ? w[i] & 32'h09090909 : w[i];
      rd_chk(OFF_WAKE_PORT, t);
    end
    for (int k = 0; k < 64; k++) begin
      t = rnd();
      ctrl = k < 32 ? tbl[k % 8] | {t[5], 5'h00} : t[5:0];
      case (t[7:6])
        2'd0: da = sta;
        2'd1: da = '1;
        default: begin
          da = {t[31:16], rnd()};
          da[0] = t[8];
        end
      endcase
      wr(OFF_CTRL, {26'h0, ctrl});
      mk(da, 14);
      send_v();
      `check_eq("accept", exp_acc(da, ctrl), v_last.accept)
      `check_eq("mcast", da[0], v_last.mcast)
      `check_eq("broadcast_disable", &da, v_last.broadcast_disable)
    end
    wake_case(0, 1'b0, 1'b1, sta, 6'h00, 4'h1, 1'b0, 1'b1);
    wake_case(1, 1'b0, 1'b0, sta, 6'h00, 4'h1, 1'b0, 1'b0);
    wake_case(2, 1'b1, 1'b1, sta, 6'h00, 4'h1, 1'b0, 1'b0);
    wake_case(3, 1'b1, 1'b1, '1, 6'h20, 4'h5, 1'b0, 1'b1);
    wake_case(1, 1'b0, 1'b1, sta, 6'h00, 4'h8, 1'b0, 1'b1);
    wake_case(2, 1'b0, 1'b1, sta, 6'h00, 4'h1, 1'b1, 1'b0);
    wr(OFF_WAKE_CS, 32'h00000002);
    wr(OFF_CTRL, 32'h0);
    mk(sta, 14);
    send_v();
    `check_eq("normal accept", 1'b1, v_last.accept)
    `check_eq("irq cleared", 1'b0, host_irq)
    // Wake mode off, last frame accepted, port pointer back at word 0.
    rd_chk(OFF_STATUS, 32'h00000002);
    report_and_stop();
  end
endmodule
